// *** microcore_path_trace_unit_bench.sv ***
`timescale 1ns/1ps
module microcore_path_trace_unit_bench;
   localparam logic [11:0] A_SYNC  = {mptu_pkg::IDX_SYNC, 2'b00};
   localparam logic [11:0] A_CFG   = {mptu_pkg::IDX_CFG, 2'b00};
   localparam logic [11:0] A_HALT  = {mptu_pkg::IDX_HALT, 2'b00};
   localparam logic [11:0] ADRS [3] = '{A_SYNC, A_CFG, A_HALT};
   localparam logic [9:0]  SYNC_A  = 10'h123;
   localparam logic [9:0]  ENTRY_A = 10'h155;
   localparam logic [9:0]  HALT_A  = 10'h2F0;
   // Kind, path, unconditional jump, expected code
   localparam logic [10:0] EV [21] = '{
      {3'h1, 3'h3, 1'b0, 4'hA}, {3'h2, 3'h0, 1'b0, 4'h5},
      {3'h2, 3'h1, 1'b0, 4'hA}, {3'h0, 3'h1, 1'b0, 4'hA},
      {3'h2, 3'h2, 1'b0, 4'h6}, {3'h2, 3'h3, 1'b0, 4'hB},
      {3'h2, 3'h4, 1'b0, 4'hD}, {3'h2, 3'h5, 1'b0, 4'h9},
      {3'h0, 3'h2, 1'b0, 4'h6}, {3'h3, 3'h1, 1'b0, 4'h1},
      {3'h3, 3'h0, 1'b0, 4'h7}, {3'h3, 3'h2, 1'b0, 4'h4},
      {3'h3, 3'h3, 1'b0, 4'h2}, {3'h3, 3'h4, 1'b0, 4'hE},
      {3'h3, 3'h5, 1'b0, 4'h3}, {3'h0, 3'h0, 1'b1, 4'hA},
      {3'h0, 3'h0, 1'b0, 4'h5}, {3'h7, 3'h0, 1'b0, 4'hC},
      {3'h4, 3'h0, 1'b0, 4'h4}, {3'h5, 3'h0, 1'b0, 4'h2}, // Interrupt entry codes
      {3'h6, 3'h0, 1'b0, 4'h3}
   };
   logic            pclk;
   logic            presetn;
   logic            ce;
   logic            psel;
   logic            penable;
   logic            pwrite;
   logic [11:0]     paddr;
   logic [31:0]     pwdata;
   logic [31:0]     prdata;
   logic            pready;
   logic            pslverr;
   logic            exec_tick;
   logic [3:0][9:0] core_pc;
   logic [3:0][2:0] core_kind;
   logic [3:0][2:0] core_path;
   logic [3:0]      core_ujump;
   logic            pin;
   logic            pin_oe;
   logic            trace_active;
   logic [3:0]      last_code;
   logic [7:0]      code_cnt;
   logic [4:0]      cal_rises;
   logic [1:0]      sel;
   int              bad_count;
   int              n_compared;

   mptu_trace_unit u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .exec_tick(exec_tick), .core_pc(core_pc),
      .core_kind(core_kind), .core_path(core_path), .core_ujump(core_ujump),
      .debug_trace_pin(pin), .debug_trace_pin_oe(pin_oe), .trace_active(trace_active));
   mptu_tracer_model u_trc (.pclk(pclk), .presetn(presetn), .exec_tick(exec_tick),
      .debug_trace_pin(pin), .debug_trace_pin_oe(pin_oe), .last_code(last_code),
      .code_cnt(code_cnt), .cal_rises(cal_rises));

   // Clock, 50 ns period
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t word %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_code(input logic [3:0] got, input logic [3:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t code %b expected %b", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t flag %b expected %b", $time, got, exp);
      end
   endtask

   // One APB transfer; idle edge after it so drivers never double-assign
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         bad_count++;
         test_done();
      end
      @(posedge pclk);
   endtask

   // Other cores sit on the halt address with a distinct path
   task automatic tick(input logic [2:0] k, input logic [2:0] p, input logic uj,
                       input logic [9:0] pc);
      for (int i = 0; i < 4; i++) begin
         core_pc[i]    <= (i == sel) ? pc : HALT_A;
         core_kind[i]  <= (i == sel) ? k : mptu_pkg::K_AUTO_RET;
         core_path[i]  <= (i == sel) ? p : mptu_pkg::P_W4;
         core_ujump[i] <= (i == sel) ? uj : 1'b0;
      end
      exec_tick <= 1'b1;
      @(posedge pclk);
      exec_tick <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask

   task automatic test_regs();
      logic [31:0] rd;
      logic        err;
      foreach (ADRS[i]) begin
         apb(1'b0, ADRS[i], 32'h0, rd, err);
         chk_word(rd, 32'h0);
         chk_bit(err, 1'b0);
      end
      apb(1'b1, A_SYNC, 32'hFFFF_F123, rd, err);
      apb(1'b1, A_HALT, 32'hFFFF_FEF0, rd, err);
      apb(1'b0, A_HALT, 32'h0, rd, err);
      chk_word(rd, {22'h0, HALT_A});
      // Frozen clock enable must not take a write
      ce <= 1'b0;
      apb(1'b1, A_SYNC, 32'h0, rd, err);
      ce <= 1'b1;
      apb(1'b0, A_SYNC, 32'h0, rd, err);
      chk_word(rd, {22'h0, SYNC_A});
      apb(1'b1, 12'h734, 32'hFFFF_FFFF, rd, err);
      chk_bit(err, 1'b1);
      apb(1'b0, 12'h729, 32'h0, rd, err);
      chk_bit(err, 1'b1);
      chk_word(rd, 32'h0);
      $display("test_regs done");
   endtask

   task automatic run_trace(input logic [1:0] s, input logic [7:0] len);
      logic [31:0] rd;
      logic        err;
      logic [7:0]  n0;
      int          n;
      sel = s;
      apb(1'b1, A_CFG, {21'h0, 1'b1, s, len}, rd, err);
      repeat (24) @(posedge pclk);
      chk_word({27'h0, cal_rises}, 32'd8);
      chk_bit(trace_active, 1'b1);
      n0 = code_cnt;
      // Gap ticks and a non-matching counter send nothing
      repeat (3) tick(3'h0, 3'h0, 1'b0, HALT_A);
      chk_word({24'h0, code_cnt}, {24'h0, n0});
      tick(3'h0, 3'h0, 1'b0, SYNC_A);
      chk_code(last_code, 4'hA);
      foreach (EV[i]) begin
         tick(EV[i][10:8], EV[i][7:5], EV[i][4], ENTRY_A);
         chk_code(last_code, EV[i][3:0]);
      end
      tick(3'h0, 3'h1, 1'b0, HALT_A);
      chk_code(last_code, 4'hF);
      n = (len == 8'hFF) ? 6 : int'(len);
      n0 = code_cnt;
      for (int i = 0; i < n; i++) tick(3'h0, 3'h0, 1'b0, 10'h155);
      chk_word({24'h0, code_cnt}, {24'h0, 8'(n0 + n)});
      if (len == 8'hFF) begin
         chk_bit(trace_active, 1'b1);
         apb(1'b1, A_CFG, {21'h0, 1'b0, s, len}, rd, err);
      end else begin
         tick(3'h0, 3'h0, 1'b0, 10'h155);
         chk_word({24'h0, code_cnt}, {24'h0, 8'(n0 + n)});
      end
      chk_bit(pin_oe, 1'b0);
      chk_bit(trace_active, 1'b0);
      apb(1'b0, A_CFG, 32'h0, rd, err);
      chk_word(rd, {21'h0, 1'b0, s, len});
      $display("run_trace core %0d length %0d done", s, len);
   endtask

   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      exec_tick = 1'b0;
      core_pc = '0;
      core_kind = '0;
      core_path = '0;
      core_ujump = '0;
      sel = 2'h0;
      bad_count = 0;
      n_compared = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      test_regs();
      for (int s = 0; s < 4; s++) run_trace(2'(s), (s == 1) ? 8'h00 : (s == 3) ? 8'hFF : 8'h02);
      test_done();
   end
endmodule

// *** mptu_pkg.sv ***
package mptu_pkg;
   // Register indices; byte address is four times the index
   localparam logic [9:0]  IDX_SYNC       = 10'h1CA;
   localparam logic [9:0]  IDX_CFG        = 10'h1CB;
   localparam logic [9:0]  IDX_HALT       = 10'h1CC;
   localparam int          ADDR_W         = 10;
   localparam logic [9:0]  SYNC_RST       = 10'h000;
   localparam logic [9:0]  HALT_RST       = 10'h000;
   localparam logic [10:0] CFG_RST        = 11'h000;
   // Configuration word layout
   localparam int          CFG_EN_BIT     = 10;
   localparam int          CFG_SEL_LSB    = 8;
   localparam int          CFG_LEN_LSB    = 0;
   localparam logic [7:0]  POST_FOREVER   = 8'hFF;
   // Calibration: eight periods at half pclk means sixteen half periods
   localparam int          CAL_CYCLES     = 8;
   localparam logic [4:0]  CAL_HALVES     = 5'(2 * CAL_CYCLES);
   localparam logic [1:0]  GAP_TICKS      = 2'h2;
   localparam logic [1:0]  CODE_BITS_LEFT = 2'h3;
   // Path codes
   localparam logic [3:0]  C_DEFAULT      = 4'h5;
   localparam logic [3:0]  C_FORK         = 4'hA;
   localparam logic [3:0]  C_STOP_SYNC    = 4'hC;
   localparam logic [3:0]  C_HALT         = 4'hF;
   localparam logic [3:0]  C_IRQ_DIAG     = 4'h4;
   localparam logic [3:0]  C_IRQ_DRV      = 4'h2;
   localparam logic [3:0]  C_IRQ_START    = 4'h3;
   localparam logic [3:0]  C_W2           = 4'h6;
   localparam logic [3:0]  C_W3           = 4'hB;
   localparam logic [3:0]  C_W4           = 4'hD;
   localparam logic [3:0]  C_W5           = 4'h9;
   localparam logic [3:0]  C_A_FORK       = 4'h1;
   localparam logic [3:0]  C_A_DEFAULT    = 4'h7;
   localparam logic [3:0]  C_A_W2         = 4'h4;
   localparam logic [3:0]  C_A_W3         = 4'h2;
   localparam logic [3:0]  C_A_W4         = 4'hE;
   localparam logic [3:0]  C_A_W5         = 4'h3;
   // Event kinds reported by a microcore each execution cycle
   localparam logic [2:0]  K_NORMAL       = 3'h0;
   localparam logic [2:0]  K_RET_RESTART  = 3'h1;
   localparam logic [2:0]  K_RET_CONT     = 3'h2;
   localparam logic [2:0]  K_AUTO_RET     = 3'h3;
   localparam logic [2:0]  K_IRQ_DIAG     = 3'h4;
   localparam logic [2:0]  K_IRQ_DRV      = 3'h5;
   localparam logic [2:0]  K_IRQ_START    = 3'h6;
   localparam logic [2:0]  K_STOP_SYNC    = 3'h7;
   // Path selected (default includes wait entry 1; fork includes waiting)
   localparam logic [2:0]  P_DEFAULT      = 3'h0;
   localparam logic [2:0]  P_FORK         = 3'h1;
   localparam logic [2:0]  P_W2           = 3'h2;
   localparam logic [2:0]  P_W3           = 3'h3;
   localparam logic [2:0]  P_W4           = 3'h4;
   localparam logic [2:0]  P_W5           = 3'h5;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_CAL   = 6'h02,
      ST_GAP   = 6'h04,
      ST_SYNC  = 6'h08,
      ST_TRACE = 6'h10,
      ST_POST  = 6'h20
   } mptu_state_t;
endpackage

// *** mptu_trace_unit.sv ***
`timescale 1ns/1ps
module mptu_trace_unit (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic             exec_tick,
   input  wire logic [3:0][9:0]  core_pc,
   input  wire logic [3:0][2:0]  core_kind,
   input  wire logic [3:0][2:0]  core_path,
   input  wire logic [3:0]       core_ujump,
   output logic                  debug_trace_pin,
   output logic                  debug_trace_pin_oe,
   output logic                  trace_active
);

   // Path code for one execution cycle of the selected core
   function automatic logic [3:0] mptu_encode(input logic [2:0] kind,
                                              input logic [2:0] path,
                                              input logic       ujump);
      logic [2:0] p;
      logic [3:0] n;
      logic [3:0] a;
      logic [3:0] c;
      p = (ujump && path == mptu_pkg::P_DEFAULT) ? mptu_pkg::P_FORK : path;
      case (p)
         mptu_pkg::P_DEFAULT: n = mptu_pkg::C_DEFAULT;
         mptu_pkg::P_FORK:    n = mptu_pkg::C_FORK;
         mptu_pkg::P_W2:      n = mptu_pkg::C_W2;
         mptu_pkg::P_W3:      n = mptu_pkg::C_W3;
         mptu_pkg::P_W4:      n = mptu_pkg::C_W4;
         default:             n = mptu_pkg::C_W5;
      endcase
      case (p)
         mptu_pkg::P_DEFAULT: a = mptu_pkg::C_A_DEFAULT;
         mptu_pkg::P_FORK:    a = mptu_pkg::C_A_FORK;
         mptu_pkg::P_W2:      a = mptu_pkg::C_A_W2;
         mptu_pkg::P_W3:      a = mptu_pkg::C_A_W3;
         mptu_pkg::P_W4:      a = mptu_pkg::C_A_W4;
         default:             a = mptu_pkg::C_A_W5;
      endcase
      case (kind)
         mptu_pkg::K_RET_RESTART: c = mptu_pkg::C_FORK;
         mptu_pkg::K_RET_CONT:    c = n;
         mptu_pkg::K_AUTO_RET:    c = a;
         mptu_pkg::K_IRQ_DIAG:    c = mptu_pkg::C_IRQ_DIAG;
         mptu_pkg::K_IRQ_DRV:     c = mptu_pkg::C_IRQ_DRV;
         mptu_pkg::K_IRQ_START:   c = mptu_pkg::C_IRQ_START;
         mptu_pkg::K_STOP_SYNC:   c = mptu_pkg::C_STOP_SYNC;
         default:                 c = n;
      endcase
      return c;
   endfunction

   // Word address decode, shared by read and write paths
   function automatic logic [1:0] mptu_decode(input logic [11:0] addr);
      logic [1:0] hit;
      hit = 2'h0;
      if (addr[1:0] != 2'h0) begin
         hit = 2'h0;
      end else if (addr[11:2] == mptu_pkg::IDX_SYNC) begin
         hit = 2'h1;
      end else if (addr[11:2] == mptu_pkg::IDX_CFG) begin
         hit = 2'h2;
      end else if (addr[11:2] == mptu_pkg::IDX_HALT) begin
         hit = 2'h3;
      end
      return hit;
   endfunction

   mptu_pkg::mptu_state_t st_r, st_nxt;
   logic [9:0]  sync_r, sync_nxt;
   logic [9:0]  halt_r, halt_nxt;
   logic [10:0] cfg_r, cfg_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic [3:0]  sh_r, sh_nxt;
   logic [1:0]  bits_r, bits_nxt;
   logic        pin_r, pin_nxt;
   logic [3:0]  last_code_r, last_code_nxt;
   logic [7:0]  post_r, post_nxt;
   logic [4:0]  cal_r, cal_nxt;
   logic [1:0]  gap_r, gap_nxt;
   logic        load;
   logic [3:0]  load_code;
   logic [1:0]  sel;
   logic [9:0]  sel_pc;
   logic [3:0]  path_code;
   logic [1:0]  hit;
   logic        wr;
   logic        rd_setup;

   // Zero-wait slave; unmapped or misaligned addresses flag an error
   assign hit      = mptu_decode(paddr);
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && (hit == 2'h0);
   assign wr       = ce && psel && penable && pwrite && (hit != 2'h0);
   assign rd_setup = ce && psel && !penable && !pwrite;
   assign prdata   = prdata_r;

   assign sel       = cfg_r[mptu_pkg::CFG_SEL_LSB +: 2];
   assign sel_pc    = core_pc[sel];
   assign path_code = mptu_encode(core_kind[sel], core_path[sel], core_ujump[sel]);

   assign debug_trace_pin    = pin_r;
   assign debug_trace_pin_oe = (st_r != mptu_pkg::ST_IDLE);
   assign trace_active       = cfg_r[mptu_pkg::CFG_EN_BIT];

   // Next state for registers, phase sequencer and serialiser
   always_comb begin
      st_nxt        = st_r;
      sync_nxt      = sync_r;
      halt_nxt      = halt_r;
      cfg_nxt       = cfg_r;
      prdata_nxt    = prdata_r;
      sh_nxt        = sh_r;
      bits_nxt      = bits_r;
      pin_nxt       = 1'b0;
      last_code_nxt = last_code_r;
      post_nxt      = post_r;
      cal_nxt       = cal_r;
      gap_nxt       = gap_r;
      load          = 1'b0;
      load_code     = path_code;
      // Read data captured in setup so it stands through the access cycle
      if (rd_setup) begin
         unique case (hit)
            2'h1:    prdata_nxt = {22'h0, sync_r};
            2'h2:    prdata_nxt = {21'h0, cfg_r};
            2'h3:    prdata_nxt = {22'h0, halt_r};
            default: prdata_nxt = 32'h0;
         endcase
      end
      // Sequencer; a code goes out on an execution tick
      unique case (st_r)
         mptu_pkg::ST_IDLE: begin
            cal_nxt = 5'h0;
            if (cfg_r[mptu_pkg::CFG_EN_BIT]) begin
               st_nxt = mptu_pkg::ST_CAL;
            end
         end
         mptu_pkg::ST_CAL: begin
            pin_nxt = !cal_r[0];
            cal_nxt = cal_r + 5'h1;
            if (cal_r == mptu_pkg::CAL_HALVES - 5'h1) begin
               st_nxt  = mptu_pkg::ST_GAP;
               gap_nxt = 2'h0;
               pin_nxt = 1'b0;
            end
         end
         mptu_pkg::ST_GAP: begin
            // low for a full period; needs two ticks to be sure
            if (exec_tick) begin
               gap_nxt = gap_r + 2'h1;
               if (gap_r == mptu_pkg::GAP_TICKS - 2'h1) begin
                  st_nxt = mptu_pkg::ST_SYNC;
               end
            end
         end
         mptu_pkg::ST_SYNC: begin
            if (exec_tick && sel_pc == sync_r) begin
               load      = 1'b1;
               load_code = mptu_pkg::C_FORK;
               st_nxt    = mptu_pkg::ST_TRACE;
            end
         end
         mptu_pkg::ST_TRACE: begin
            if (exec_tick) begin
               load = 1'b1;
               if (sel_pc == halt_r) begin
                  load_code = mptu_pkg::C_HALT;
                  st_nxt    = mptu_pkg::ST_POST;
                  post_nxt  = cfg_r[mptu_pkg::CFG_LEN_LSB +: 8];
               end
            end
         end
         mptu_pkg::ST_POST: begin
            if (exec_tick) begin
               if (post_r == 8'h0) begin
                  st_nxt                         = mptu_pkg::ST_IDLE;
                  cfg_nxt[mptu_pkg::CFG_EN_BIT] = 1'b0;
               end else begin
                  load = 1'b1;
                  if (post_r != mptu_pkg::POST_FOREVER) begin
                     post_nxt = post_r - 8'h1;
                  end
               end
            end
         end
      endcase
      // MSB first, remaining bits at pclk rate
      if (load) begin
         last_code_nxt = load_code;
         pin_nxt       = load_code[3];
         sh_nxt        = {load_code[2:0], 1'b0};
         bits_nxt      = mptu_pkg::CODE_BITS_LEFT;
      end else if (bits_r != 2'h0) begin
         pin_nxt  = sh_r[3];
         sh_nxt   = {sh_r[2:0], 1'b0};
         bits_nxt = bits_r - 2'h1;
      end
      // Software write last so a set of enable beats the completion clear
      if (wr) begin
         unique case (hit)
            2'h1: sync_nxt = pwdata[mptu_pkg::ADDR_W-1:0];
            2'h3: halt_nxt = pwdata[mptu_pkg::ADDR_W-1:0];
            default: begin
               cfg_nxt = pwdata[10:0];
               if (!pwdata[mptu_pkg::CFG_EN_BIT]) begin
                  st_nxt   = mptu_pkg::ST_IDLE;
                  bits_nxt = 2'h0;
                  pin_nxt  = 1'b0;
               end
            end
         endcase
      end
   end

   // All state frozen while ce is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r        <= mptu_pkg::ST_IDLE;
         sync_r      <= mptu_pkg::SYNC_RST;
         halt_r      <= mptu_pkg::HALT_RST;
         cfg_r       <= mptu_pkg::CFG_RST;
         prdata_r    <= 32'h0;
         sh_r        <= 4'h0;
         bits_r      <= 2'h0;
         pin_r       <= 1'b0;
         last_code_r <= 4'h0;
         post_r      <= 8'h0;
         cal_r       <= 5'h0;
         gap_r       <= 2'h0;
      end else if (ce) begin
         st_r        <= st_nxt;
         sync_r      <= sync_nxt;
         halt_r      <= halt_nxt;
         cfg_r       <= cfg_nxt;
         prdata_r    <= prdata_nxt;
         sh_r        <= sh_nxt;
         bits_r      <= bits_nxt;
         pin_r       <= pin_nxt;
         last_code_r <= last_code_nxt;
         post_r      <= post_nxt;
         cal_r       <= cal_nxt;
         gap_r       <= gap_nxt;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic trace_tick;
   assign trace_tick = ce && exec_tick && !wr && (st_r == mptu_pkg::ST_TRACE);

   AST_RESTART_CODE: assert property (trace_tick && sel_pc != halt_r &&
      core_kind[sel] == mptu_pkg::K_RET_RESTART |=> last_code_r == 4'hA)
      else $error("restart return did not send 1010");
   AST_CONT_NO_IRQ: assert property (trace_tick && sel_pc != halt_r &&
      core_kind[sel] == mptu_pkg::K_RET_CONT |=>
      !(last_code_r inside {4'h2, 4'h3, 4'h4}))
      else $error("continue return sent an interrupt code");
   AST_AUTO_FORK: assert property (trace_tick && sel_pc != halt_r &&
      core_kind[sel] == mptu_pkg::K_AUTO_RET && core_path[sel] == mptu_pkg::P_FORK
      |=> last_code_r == 4'h1)
      else $error("automatic forked return did not send 0001");
   AST_AUTO_DEFAULT: assert property (trace_tick && sel_pc != halt_r &&
      core_kind[sel] == mptu_pkg::K_AUTO_RET && !core_ujump[sel] &&
      core_path[sel] == mptu_pkg::P_DEFAULT |=> last_code_r == 4'h7)
      else $error("automatic default return did not send 0111");
   AST_HALT_ENTRY: assert property (trace_tick && sel_pc == halt_r |=>
      st_r == mptu_pkg::ST_POST && last_code_r == 4'hF && pin_r)
      else $error("halt match did not send 1111 and enter post phase");
   AST_SYNC_ENTRY: assert property (ce && exec_tick && !wr &&
      st_r == mptu_pkg::ST_SYNC && sel_pc == sync_r |=>
      st_r == mptu_pkg::ST_TRACE && last_code_r == 4'hA)
      else $error("sync match did not start the trace phase");
   AST_MSB_FIRST: assert property (ce && load && !wr ##1 ce && !load && !wr |=>
      pin_r == last_code_r[2] && $past(pin_r) == last_code_r[3])
      else $error("code not shifted most significant bit first");
   AST_SW_STOP: assert property (wr && hit == 2'h2 &&
      !pwdata[mptu_pkg::CFG_EN_BIT] |=> st_r == mptu_pkg::ST_IDLE && !pin_r)
      else $error("clearing enable did not stop at once");
   AST_GAP_LOW: assert property (st_r == mptu_pkg::ST_GAP |-> !pin_r)
      else $error("pin not low after calibration burst");
   AST_SELF_CLEAR: assert property (ce && !wr && st_r == mptu_pkg::ST_POST &&
      exec_tick && post_r == 8'h0 |=> st_r == mptu_pkg::ST_IDLE && !trace_active)
      else $error("post phase did not end and clear enable");

   COV_SYNC: cover property (st_r == mptu_pkg::ST_SYNC ##1 st_r == mptu_pkg::ST_TRACE);
   COV_HALT: cover property (st_r == mptu_pkg::ST_TRACE ##1 st_r == mptu_pkg::ST_POST);
   COV_DONE: cover property (st_r == mptu_pkg::ST_POST ##1 st_r == mptu_pkg::ST_IDLE);
endmodule

// *** mptu_tracer_model.sv ***
`timescale 1ns/1ps
// Far-side tracer: frames each code from the tick and decodes the pin
module mptu_tracer_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       exec_tick,
   input  wire logic       debug_trace_pin,
   input  wire logic       debug_trace_pin_oe,
   output logic [3:0]      last_code,
   output logic [7:0]      code_cnt,
   output logic [4:0]      cal_rises
);
   logic [3:0] shreg;
   logic [2:0] left;
   logic       pin_q;
   logic       oe_q;
   logic       framed;

   // Receiver; 0000 is idle line, never a code, so it is dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_code <= 4'h0;
         code_cnt  <= 8'h00;
         cal_rises <= 5'h00;
         shreg     <= 4'h0;
         left      <= 3'h0;
         pin_q     <= 1'b0;
         oe_q      <= 1'b0;
         framed    <= 1'b0;
      end else begin
         pin_q <= debug_trace_pin;
         oe_q  <= debug_trace_pin_oe;
         // Calibration edges counted until the first framed tick
         if (debug_trace_pin_oe && !oe_q) begin
            cal_rises <= {4'h0, debug_trace_pin};
            framed    <= 1'b0;
         end else if (debug_trace_pin_oe && !framed && debug_trace_pin && !pin_q) begin
            cal_rises <= cal_rises + 5'h01;
         end
         if (left != 3'h0) begin
            shreg <= {shreg[2:0], debug_trace_pin};
            left  <= left - 3'h1;
            if (left == 3'h1 && {shreg[2:0], debug_trace_pin} != 4'h0) begin
               last_code <= {shreg[2:0], debug_trace_pin};
               code_cnt  <= code_cnt + 8'h01;
            end
         end
         if (exec_tick && debug_trace_pin_oe) begin
            left   <= 3'h4;
            framed <= 1'b1;
         end
      end
   end
endmodule
